// ==== logic/scl_defs.svh ====
// Offsets, field positions, reset values and timing counts of the start-up loader
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH
`define SCL_BOOT_SOURCE_CONFIG_ADDR 15'h0014
`define SCL_SOFT_RESTART_ADDR       15'h0017
`define SCL_SOFT_RESTART_BIT        6
`define SCL_OVERLAY_BIT             7
`define SCL_PAGE_SEL_HI             6
`define SCL_PAGE_SEL_LO             3
`define SCL_BOOT_SOURCE_RESET       8'h00
`define SCL_NUM_PAGES               9
`define SCL_SETTLE_CYCLES           8'h10
`define SCL_LOW_POWER_PAGE          4'h3
`endif

// ==== logic/scl_loader.sv ====
// Start-up configuration loader: strap capture, rom page pick, eeprom overlay
`timescale 1ns/1ps
`include "scl_defs.svh"

// Operation
// - Interface strap sampled at power-on as two-level; picks serial interface.
// - Strap low: i2c client, address pin is three-level address select.
// - Strap high: spi, address pin acts as chip select.
// - Rom page from both page straps plus page-select field.
// - Page-select field comes from eeprom, factory default zero.
// - Rom pages are constants; no write can change them.
// - Field zero, two-level straps: LL0, LH1, HL2, HH3, upper first.
// - Page 3 is low power: all loops off, all outputs off.
// - Mid straps: LM4, ML5, MM6, MH7, HM8.
// - Eeprom never sets digital-loop, frame-ref or gpio settings.
// - Unsuitable digital-loop settings make analog loops lock to crystal.
// - Loop references eligible only after host configures digital loop.
// - Overlay enable is bit 7 of register 20, eeprom held, default 0.
// - Overlay off: rom page settings only.
// - Overlay on: eeprom overwrites crystal, analog-loop, output settings after rom.
// - Active register space kept apart from rom, eeprom and sram.
// - Each rom page is a complete register image.
// - Eeprom is a partial image, reprogrammable by the host.
// - Sram mirrors eeprom map and only stages eeprom programming.
// - Low-rate frame outputs are driven from the frame channel divider.
// - Configured-but-disabled and unconfigured channels stay disabled.
// - Power-on sequence starts when power-down pin goes high.
// - Soft restart bit 6 of register 23 reruns initialisation.
module scl_loader
	import scl_pkg::*;
#(
	parameter int SETTLE = 16
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         power_down_n_pin,
	input  wire logic         iface_select_strap,
	input  wire logic [1:0]   addr_or_chip_select_pin,
	input  wire logic [1:0]   page_strap_upper,
	input  wire logic [1:0]   page_strap_lower,
	input  wire logic [7:0]   eeprom_boot_source,
	input  wire scl_overlay_t eeprom_overlay,
	input  wire scl_reg_wr_t  reg_wr,
	input  wire logic         digital_loop_valid,
	output logic [7:0]        reg_rdata,
	output logic              iface_spi,
	output logic [1:0]        i2c_addr_lsb,
	output logic              spi_chip_select_n,
	output logic [3:0]        rom_page,
	output logic              page_invalid,
	output scl_image_t        active_config,
	output logic              lock_to_crystal,
	output logic              loops_eligible,
	output logic              boot_done,
	output logic              restart_pulse
);
	// Settle count lives in an eight-bit counter and must run at least once
	if (SETTLE < 1 || SETTLE > 255) begin : g_settle_range
		$error("SETTLE out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: only the second stage is read
	// A strap moving during capture may be seen a cycle late; it is only read once
	logic [7:0] sync1;
	logic [7:0] sync2;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 8'h00;
			sync2 <= 8'h00;
		end else begin
			sync1 <= {power_down_n_pin, iface_select_strap, addr_or_chip_select_pin,
				page_strap_upper, page_strap_lower};
			sync2 <= sync1;
		end
	end
	wire logic       pd_n_s  = sync2[7];
	wire logic       ifs_s   = sync2[6];
	wire logic [1:0] addr_s  = sync2[5:4];
	wire logic [1:0] upper_s = sync2[3:2];
	wire logic [1:0] lower_s = sync2[1:0];

	////////////////////////////////////////////////////////////////////////////////
	// Fixed rom images, constants only so nothing can write them
	function automatic scl_image_t rom_image(input logic [3:0] pg);
		scl_image_t im;
		im = '{8'h01, 8'h01, 8'h00, 8'h30, 8'h01, 16'hFFFF, 16'h0000};
		unique case (pg)
			4'h0: im = '{8'h01, 8'h01, 8'h00, 8'h30, 8'h07, 16'hFFFF, 16'h2A00};
			4'h1: im = '{8'h02, 8'h01, 8'h00, 8'h30, 8'h07, 16'h4048, 16'h2A81};
			4'h2: im = '{8'h02, 8'h01, 8'h00, 8'h30, 8'h07, 16'hD56E, 16'h2A91};
			// Low power: every loop and every output off
			4'h3: im = '{8'h00, 8'h00, 8'h00, 8'h26, 8'h00, 16'h0000, 16'h0000};
			// Two channels carry no frequency and stay off
			4'h4: im = '{8'h03, 8'h00, 8'h00, 8'h36, 8'h07, 16'h3FFF, 16'h0000};
			4'h5: im = '{8'h04, 8'h01, 8'h00, 8'h14, 8'h07, 16'h3FFF, 16'hAA80};
			4'h6: im = '{8'h04, 8'h01, 8'h00, 8'h30, 8'h07, 16'h207E, 16'h2A01};
			4'h7: im = '{8'h04, 8'h01, 8'h00, 8'h30, 8'h07, 16'h2FFF, 16'h2A81};
			4'h8: im = '{8'h05, 8'h01, 8'h00, 8'h30, 8'h07, 16'hFFFF, 16'h55A0};
			default: im = '{8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 16'h0000, 16'h0000};
		endcase
		return im;
	endfunction : rom_image

	// Strap pair to page; 4'hF marks a combination with no page
	function automatic logic [3:0] strap_page(input scl_level_t up, input scl_level_t lo);
		logic [3:0] p;
		p = 4'hF;
		unique case ({up, lo})
			{SCL_LVL_LOW,  SCL_LVL_LOW }: p = 4'h0;
			{SCL_LVL_LOW,  SCL_LVL_HIGH}: p = 4'h1;
			{SCL_LVL_HIGH, SCL_LVL_LOW }: p = 4'h2;
			{SCL_LVL_HIGH, SCL_LVL_HIGH}: p = 4'h3;
			{SCL_LVL_LOW,  SCL_LVL_MID }: p = 4'h4;
			{SCL_LVL_MID,  SCL_LVL_LOW }: p = 4'h5;
			{SCL_LVL_MID,  SCL_LVL_MID }: p = 4'h6;
			{SCL_LVL_MID,  SCL_LVL_HIGH}: p = 4'h7;
			{SCL_LVL_HIGH, SCL_LVL_MID }: p = 4'h8;
			default: p = 4'hF;
		endcase
		return p;
	endfunction : strap_page

	// Pin code 00 low, 01 mid, 11 high, 10 illegal
	function automatic scl_level_t decode3(input logic [1:0] v);
		unique case (v)
			2'h0: return SCL_LVL_LOW;
			2'h1: return SCL_LVL_MID;
			2'h3: return SCL_LVL_HIGH;
			default: return SCL_LVL_BAD;
		endcase
	endfunction : decode3

	////////////////////////////////////////////////////////////////////////////////
	// State: one packed struct, one comb, one ff
	scl_state_pack_t st;
	scl_state_pack_t next_st;
	logic [4:0]      page_sum;
	logic [3:0]      strap_pg;
	logic            restart;

	// Soft restart write seen on the register port
	assign restart = reg_wr.wr && reg_wr.addr == `SCL_SOFT_RESTART_ADDR
		&& reg_wr.data[`SCL_SOFT_RESTART_BIT];

	// Page is strap page plus field; sums past the last page are refused
	// Five bits wide so a large field on a high strap page cannot wrap to a legal one
	assign strap_pg = strap_page(st.strap_upper, st.strap_lower);
	assign page_sum = {1'b0, strap_pg} + {1'b0,
		st.boot_source_config[`SCL_PAGE_SEL_HI:`SCL_PAGE_SEL_LO]};

	always_comb begin
		next_st = st;
		unique case (st.state)
			SCL_ST_WAIT: begin
				// Sequence starts once power-down is released
				if (pd_n_s) begin
					next_st.state = SCL_ST_SETTLE;
					next_st.count = 8'(SETTLE);
				end
			end
			SCL_ST_SETTLE: begin
				if (st.count == 8'h01) begin
					// Straps captured once here and then held
					next_st.iface_spi   = ifs_s;
					next_st.addr_level  = decode3(addr_s);
					next_st.strap_upper = decode3(upper_s);
					next_st.strap_lower = decode3(lower_s);
					// Field loaded from eeprom copy
					next_st.boot_source_config = eeprom_boot_source;
					next_st.state = SCL_ST_ROM;
				end else begin
					next_st.count = st.count - 8'h01;
				end
			end
			SCL_ST_ROM: begin
				if (strap_pg == 4'hF || page_sum >= 5'(`SCL_NUM_PAGES)) begin
					next_st.page_valid = 1'b0;
					next_st.state = SCL_ST_FAULT;
				end else begin
					next_st.page       = page_sum[3:0];
					next_st.page_valid = 1'b1;
					next_st.active     = rom_image(page_sum[3:0]);
					// Overlay bit picks the overlay pass
					next_st.state = st.boot_source_config[`SCL_OVERLAY_BIT] ?
						SCL_ST_OVERLAY : SCL_ST_RUN;
				end
			end
			SCL_ST_OVERLAY: begin
				// Only the partial image is replaced
				// Only committed eeprom copies feed this; the sram staging area never does
				next_st.active.crystal_ref = eeprom_overlay.crystal_ref;
				next_st.active.analog_loop = eeprom_overlay.analog_loop;
				next_st.active.out_enable  = eeprom_overlay.out_enable;
				next_st.state = SCL_ST_RUN;
			end
			SCL_ST_RUN: begin
				next_st.boot_done = 1'b1;
				// Host rewrites active copies only
				if (reg_wr.wr && reg_wr.addr == `SCL_BOOT_SOURCE_CONFIG_ADDR)
					next_st.boot_source_config = reg_wr.data;
				// Digital loop becomes a lock source only once configured
				if (digital_loop_valid)
					next_st.loops_eligible = 1'b1;
			end
			SCL_ST_FAULT: begin
				next_st.boot_done = 1'b1;
			end
			default: next_st.state = SCL_ST_WAIT;
		endcase
		// Restart reruns loading but keeps straps
		// A restart while booting is dropped; that boot reloads everything anyway
		if (restart && (st.state == SCL_ST_RUN || st.state == SCL_ST_FAULT)) begin
			next_st.state = SCL_ST_ROM;
			next_st.boot_source_config = eeprom_boot_source;
			next_st.boot_done = 1'b0;
			next_st.loops_eligible = 1'b0;
		end
		// Power-down wins, even over a restart in the same cycle
		if (!pd_n_s) begin
			next_st.state = SCL_ST_WAIT;
			next_st.boot_done = 1'b0;
			next_st.loops_eligible = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{SCL_ST_WAIT, 8'h00, 1'b0, SCL_LVL_LOW, SCL_LVL_LOW, SCL_LVL_LOW,
				`SCL_BOOT_SOURCE_RESET, 4'h0, 1'b0, '0, 1'b0, 1'b0};
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign iface_spi         = st.iface_spi;
	// Address pin meaning follows the captured strap
	assign i2c_addr_lsb      = st.iface_spi ? 2'h0 :
		(st.addr_level == SCL_LVL_MID ? 2'h2 : st.addr_level == SCL_LVL_HIGH ? 2'h1 : 2'h0);
	// Chip select follows the live pin once spi is chosen; only the mode is captured
	assign spi_chip_select_n = st.iface_spi ? addr_s[0] : 1'b1;
	assign rom_page          = st.page;
	assign page_invalid      = st.state == SCL_ST_FAULT;
	// Frame divider routing travels inside the image
	assign active_config     = st.active;
	// Without a configured digital loop the analog loops use the crystal
	assign lock_to_crystal   = !st.loops_eligible;
	assign loops_eligible    = st.loops_eligible;
	assign boot_done         = st.boot_done;
	assign restart_pulse     = restart;
	assign reg_rdata         = st.boot_source_config;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	// Checked right after the rom load, before any overlay may replace the outputs
	chk_low_power_page: assert property (@(posedge mclk) disable iff (!rst_n)
		st.state == SCL_ST_ROM && strap_pg != 4'hF && page_sum == {1'b0, `SCL_LOW_POWER_PAGE}
		|=> active_config.out_enable == 16'h0000 && active_config.analog_loop == 8'h00
		&& active_config.digital_loop == 8'h00)
		else $error("low power page has outputs on");

	chk_overlay_path: assert property (@(posedge mclk) disable iff (!rst_n)
		st.state == SCL_ST_ROM && next_st.state == SCL_ST_OVERLAY |=> ##1
		active_config.analog_loop == $past(eeprom_overlay.analog_loop))
		else $error("overlay not applied");

	chk_overlay_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
		st.state == SCL_ST_OVERLAY |=> $stable(active_config.digital_loop)
		&& $stable(active_config.gpio_cfg) && $stable(active_config.frame_reference))
		else $error("overlay touched rom-only settings");

	chk_no_overlay: assert property (@(posedge mclk) disable iff (!rst_n)
		st.state == SCL_ST_ROM && !st.boot_source_config[7] && next_st.page_valid
		|=> st.state == SCL_ST_RUN)
		else $error("overlay taken while disabled");

	chk_strap_held: assert property (@(posedge mclk) disable iff (!rst_n)
		st.state == SCL_ST_RUN |=> $stable(iface_spi) && $stable(st.strap_upper))
		else $error("strap capture changed");

	chk_page_pick: assert property (@(posedge mclk) disable iff (!rst_n)
		st.state == SCL_ST_ROM && st.boot_source_config[6:3] == 4'h0
		&& st.strap_upper == SCL_LVL_HIGH && st.strap_lower == SCL_LVL_LOW |=> rom_page == 4'h2)
		else $error("wrong page for high/low");

	chk_mid_page: assert property (@(posedge mclk) disable iff (!rst_n)
		st.state == SCL_ST_ROM && st.boot_source_config[6:3] == 4'h0
		&& st.strap_upper == SCL_LVL_MID && st.strap_lower == SCL_LVL_MID |=> rom_page == 4'h6)
		else $error("wrong page for mid/mid");

	chk_restart: assert property (@(posedge mclk) disable iff (!rst_n)
		restart && st.state == SCL_ST_RUN && pd_n_s |=> st.state == SCL_ST_ROM ##1 !boot_done)
		else $error("restart ignored");

	chk_crystal: assert property (@(posedge mclk) disable iff (!rst_n)
		!digital_loop_valid && !loops_eligible |=> lock_to_crystal)
		else $error("locked without digital loop");

	chk_fault_no_load: assert property (@(posedge mclk) disable iff (!rst_n)
		st.state == SCL_ST_ROM && (strap_pg == 4'hF || page_sum >= 5'(`SCL_NUM_PAGES))
		|=> $stable(active_config) && !boot_done)
		else $error("invalid page selection loaded");

	chk_field_capture: assert property (@(posedge mclk) disable iff (!rst_n)
		st.state == SCL_ST_SETTLE && st.count == 8'h01
		|=> reg_rdata == $past(eeprom_boot_source))
		else $error("boot source field not taken from eeprom");

	chk_host_write: assert property (@(posedge mclk) disable iff (!rst_n)
		st.state == SCL_ST_RUN && reg_wr.wr && reg_wr.addr == `SCL_BOOT_SOURCE_CONFIG_ADDR
		|=> reg_rdata == $past(reg_wr.data))
		else $error("host write to boot source lost");

	chk_eligible_cfg: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(loops_eligible) |-> $past(digital_loop_valid))
		else $error("loops eligible without configuration");

	chk_pd_holds: assert property (@(posedge mclk) disable iff (!rst_n)
		!pd_n_s |=> st.state == SCL_ST_WAIT && !boot_done)
		else $error("boot ran while powered down");

	chk_restart_field: assert property (@(posedge mclk) disable iff (!rst_n)
		restart && st.state == SCL_ST_RUN && pd_n_s |=> reg_rdata == $past(eeprom_boot_source))
		else $error("restart did not reload the boot source field");

	// Main scenarios that the bench should reach
	cov_overlay: cover property (@(posedge mclk) st.state == SCL_ST_OVERLAY);
	cov_fault: cover property (@(posedge mclk) st.state == SCL_ST_FAULT);
	cov_spi: cover property (@(posedge mclk) boot_done && iface_spi);
	cov_restart: cover property (@(posedge mclk) restart && st.state == SCL_ST_RUN);
	cov_mid_page: cover property (@(posedge mclk) st.state == SCL_ST_RUN && st.page == 4'h6);
endmodule : scl_loader

// ==== logic/scl_pkg.sv ====
// Types shared by the start-up configuration loader
package scl_pkg;
	typedef enum logic [1:0] {
		SCL_LVL_LOW  = 2'h0,
		SCL_LVL_MID  = 2'h1,
		SCL_LVL_HIGH = 2'h2,
		SCL_LVL_BAD  = 2'h3
	} scl_level_t;

	typedef enum logic [5:0] {
		SCL_ST_WAIT    = 6'h01,
		SCL_ST_SETTLE  = 6'h02,
		SCL_ST_ROM     = 6'h04,
		SCL_ST_OVERLAY = 6'h08,
		SCL_ST_RUN     = 6'h10,
		SCL_ST_FAULT   = 6'h20
	} scl_state_t;

	// One complete register image; eeprom holds only the crystal/analog/output part
	typedef struct packed {
		logic [7:0]  digital_loop;
		logic [7:0]  frame_reference;
		logic [7:0]  gpio_cfg;
		logic [7:0]  crystal_ref;
		logic [7:0]  analog_loop;
		logic [15:0] out_enable;
		logic [15:0] out_from_frame_div;
	} scl_image_t;

	typedef struct packed {
		logic [7:0]  crystal_ref;
		logic [7:0]  analog_loop;
		logic [15:0] out_enable;
	} scl_overlay_t;

	// Register write port from the serial interface engine
	typedef struct packed {
		logic        wr;
		logic [14:0] addr;
		logic [7:0]  data;
	} scl_reg_wr_t;

	typedef struct packed {
		scl_state_t state;
		logic [7:0] count;
		logic       iface_spi;
		scl_level_t addr_level;
		scl_level_t strap_upper;
		scl_level_t strap_lower;
		logic [7:0] boot_source_config;
		logic [3:0] page;
		logic       page_valid;
		scl_image_t active;
		logic       loops_eligible;
		logic       boot_done;
	} scl_state_pack_t;
endpackage : scl_pkg

// ==== verification/scl_host_model.sv ====
// Behavioural host controller issuing register writes to the loader
`timescale 1ns/1ps
module scl_host_model
	import scl_pkg::*;
(
	input  wire logic   mclk,
	output scl_reg_wr_t reg_wr
);
	initial reg_wr = '0;

	////////////////////////////////////////////////////////////////////////////
	// Raise a write strobe; it stays up until stop so one posedge samples it
	task automatic start(input logic [14:0] addr, input logic [7:0] data);
		@(negedge mclk);
		reg_wr.addr = addr;
		reg_wr.data = data;
		reg_wr.wr   = 1'b1;
	endtask : start

	// Released bus shows inverted junk so a stale value never looks valid
	task automatic stop();
		@(negedge mclk);
		reg_wr.wr   = 1'b0;
		reg_wr.addr = ~reg_wr.addr;
		reg_wr.data = ~reg_wr.data;
	endtask : stop
endmodule : scl_host_model

// ==== verification/startup_config_loader_tb_top.sv ====
// Self-checking bench for the start-up configuration loader
`timescale 1ns/1ps
`include "scl_defs.svh"
module startup_config_loader_tb_top
	import scl_pkg::*;
;
	logic         mclk;
	logic         rst_n;
	logic         power_down_n_pin;
	logic         iface_select_strap;
	logic         digital_loop_valid;
	logic [1:0]   addr_or_chip_select_pin;
	logic [1:0]   page_strap_upper;
	logic [1:0]   page_strap_lower;
	logic [7:0]   eeprom_boot_source;
	logic [7:0]   reg_rdata;
	scl_overlay_t eeprom_overlay;
	scl_reg_wr_t  reg_wr;
	logic         iface_spi;
	logic         spi_chip_select_n;
	logic         page_invalid;
	logic         lock_to_crystal;
	logic         loops_eligible;
	logic         boot_done;
	logic         restart_pulse;
	logic [1:0]   i2c_addr_lsb;
	logic [3:0]   rom_page;
	scl_image_t   active_config;
	scl_image_t   p3_img;
	int           failures = 0;
	int           samples_checked = 0;
	// Strap pairs per page, upper first; codes 00 low, 01 mid, 11 high
	logic [1:0]   up_t [9] = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h1, 2'h1, 2'h1, 2'h3};
	logic [1:0]   lo_t [9] = '{2'h0, 2'h3, 2'h0, 2'h3, 2'h1, 2'h0, 2'h1, 2'h3, 2'h1};
	logic [1:0]   ad_t [3] = '{2'h0, 2'h1, 2'h3};
	logic [1:0]   ae_t [3] = '{2'h0, 2'h2, 2'h1};

	////////////////////////////////////////////////////////////////////////////
	// Short settle keeps each boot around twenty-five cycles
	scl_loader #(.SETTLE(2)) u_scl_loader (
		.mclk                    (mclk),
		.rst_n                   (rst_n),
		.power_down_n_pin        (power_down_n_pin),
		.iface_select_strap      (iface_select_strap),
		.addr_or_chip_select_pin (addr_or_chip_select_pin),
		.page_strap_upper        (page_strap_upper),
		.page_strap_lower        (page_strap_lower),
		.eeprom_boot_source      (eeprom_boot_source),
		.eeprom_overlay          (eeprom_overlay),
		.reg_wr                  (reg_wr),
		.digital_loop_valid      (digital_loop_valid),
		.reg_rdata               (reg_rdata),
		.iface_spi               (iface_spi),
		.i2c_addr_lsb            (i2c_addr_lsb),
		.spi_chip_select_n       (spi_chip_select_n),
		.rom_page                (rom_page),
		.page_invalid            (page_invalid),
		.active_config           (active_config),
		.lock_to_crystal         (lock_to_crystal),
		.loops_eligible          (loops_eligible),
		.boot_done               (boot_done),
		.restart_pulse           (restart_pulse)
	);
	scl_host_model u_scl_host_model (.mclk(mclk), .reg_wr(reg_wr));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk

	task automatic wait_done();
		int n;
		n = 0;
		while (boot_done !== 1'b1 && page_invalid !== 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		chk("boot_finish", 1, n < 200);
	endtask : wait_done

	// Full power-on: reset held 16 cycles, then power-down pin released
	task automatic boot(input logic [1:0] up, input logic [1:0] lo, input logic [7:0] src);
		@(negedge mclk);
		rst_n = 1'b0;
		power_down_n_pin = 1'b0;
		page_strap_upper = up;
		page_strap_lower = lo;
		eeprom_boot_source = src;
		repeat (16) @(negedge mclk);
		rst_n = 1'b1;
		@(negedge mclk);
		power_down_n_pin = 1'b1;
		wait_done();
	endtask : boot

	task automatic conclude();
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	// Watchdog far beyond the roughly five hundred cycles the tests need
	initial begin
		#100000;
		failures++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		rst_n = 1'b0;
		power_down_n_pin = 1'b0;
		iface_select_strap = 1'b0;
		digital_loop_valid = 1'b0;
		addr_or_chip_select_pin = 2'h1;
		page_strap_upper = 2'h0;
		page_strap_lower = 2'h0;
		eeprom_boot_source = 8'h00;
		eeprom_overlay = '{crystal_ref: 8'h5A, analog_loop: 8'hC3, out_enable: 16'hFFFF};
		// Every strap pair with a zero field
		for (int i = 0; i < 9; i++) begin
			boot(up_t[i], lo_t[i], 8'h00);
			chk("rom_page", i, rom_page);
			chk("page_invalid", 0, page_invalid);
			chk("lock_to_crystal", 1, lock_to_crystal);
			chk("loops_eligible", 0, loops_eligible);
			chk("boot_done", 1, boot_done);
			chk("spi_cs_idle", 1, spi_chip_select_n);
			if (i == 3) begin
				p3_img = active_config;
				chk("p3_digital_loop", 0, active_config.digital_loop);
				chk("p3_analog_loop", 0, active_config.analog_loop);
				chk("p3_out_enable", 0, active_config.out_enable);
			end
		end
		chk("reg_rdata_default", 8'h00, reg_rdata);
		chk("iface_spi_i2c", 0, iface_spi);
		// Field adds to the strap page; sums past eight and bad codes refuse
		boot(2'h0, 2'h0, 8'h10);
		chk("rom_page_field", 2, rom_page);
		boot(2'h3, 2'h1, 8'h08);
		chk("page_invalid_sum", 1, page_invalid);
		boot(2'h2, 2'h0, 8'h00);
		chk("page_invalid_code", 1, page_invalid);
		// Overlay replaces crystal, analog-loop and output settings
		eeprom_overlay = '{crystal_ref: 8'h5A, analog_loop: 8'hC3, out_enable: 16'h1234};
		boot(2'h3, 2'h3, 8'h80);
		chk("ov_rom_page", 3, rom_page);
		chk("ov_crystal", 8'h5A, active_config.crystal_ref);
		chk("ov_analog", 8'hC3, active_config.analog_loop);
		chk("ov_out_enable", 16'h1234, active_config.out_enable);
		chk("ov_digital_loop", 0, active_config.digital_loop);
		chk("ov_frame_ref", p3_img.frame_reference, active_config.frame_reference);
		chk("ov_gpio_cfg", p3_img.gpio_cfg, active_config.gpio_cfg);
		chk("ov_frame_div", p3_img.out_from_frame_div, active_config.out_from_frame_div);
		chk("reg_rdata_ov", 8'h80, reg_rdata);
		// Address pin levels as i2c address low bits
		for (int j = 0; j < 3; j++) begin
			addr_or_chip_select_pin = ad_t[j];
			boot(2'h0, 2'h0, 8'h00);
			chk("i2c_addr_lsb", ae_t[j], i2c_addr_lsb);
		end
		// Spi mode: pin becomes chip select
		iface_select_strap = 1'b1;
		addr_or_chip_select_pin = 2'h0;
		boot(2'h0, 2'h0, 8'h00);
		chk("iface_spi", 1, iface_spi);
		chk("spi_cs_low", 0, spi_chip_select_n);
		addr_or_chip_select_pin = 2'h3;
		repeat (4) @(negedge mclk);
		chk("spi_cs_high", 1, spi_chip_select_n);
		// Later strap changes must not move captured choices
		iface_select_strap = 1'b0;
		page_strap_upper = 2'h3;
		page_strap_lower = 2'h3;
		repeat (4) @(negedge mclk);
		chk("iface_held", 1, iface_spi);
		chk("page_held", 0, rom_page);
		// Host configures the digital loop
		digital_loop_valid = 1'b1;
		repeat (4) @(negedge mclk);
		chk("loops_eligible_on", 1, loops_eligible);
		chk("lock_to_crystal_off", 0, lock_to_crystal);
		// Host rewrites register 20 in run
		u_scl_host_model.start(`SCL_BOOT_SOURCE_CONFIG_ADDR, 8'h18);
		u_scl_host_model.stop();
		repeat (2) @(negedge mclk);
		chk("reg_rdata_wr", 8'h18, reg_rdata);
		// Soft restart reloads with the new eeprom field and kept straps
		eeprom_boot_source = 8'h08;
		u_scl_host_model.start(`SCL_SOFT_RESTART_ADDR, 8'h40);
		#1;
		chk("restart_pulse", 1, restart_pulse);
		u_scl_host_model.stop();
		n = 0;
		while (boot_done === 1'b1 && n < 50) begin
			@(negedge mclk);
			n++;
		end
		chk("restart_drop", 1, n < 50);
		wait_done();
		chk("restart_page", 1, rom_page);
		// Power-down mid-run stops the loader; release is a fresh power-on
		power_down_n_pin = 1'b0;
		repeat (4) @(negedge mclk);
		chk("pd_boot_done", 0, boot_done);
		power_down_n_pin = 1'b1;
		wait_done();
		chk("pd_rom_page", 4, rom_page);
		chk("pd_iface", 0, iface_spi);
		conclude();
	end
endmodule : startup_config_loader_tb_top
